// file: lec_defines.vh
// constants for the link error classifier
// Operation
// - check received traffic; a fatal error sets device status bit 2.
// - send an upstream error message only when its reporting enable is set.
// - training, link protocol, flow control, malformed, rx overflow are fatal.
// - rx error, bad packet, bad link packet, replay timeout, rollover are correctable.
// - poisoned, end-to-end crc, unsupported, timeout, abort, unexpected, acs are non-fatal.
// - transmitter resends unacknowledged packet on timeout and raises replay errors.
// - receive path detects rx error, bad packet, bad link packet as correctable.
// - errors from own transmitted traffic never reach own status.
// - request address outside every base address range flags unsupported request.
// - requester reports completion timeout when no completion returns.
`ifndef LEC_DEFINES_VH
`define LEC_DEFINES_VH
// event vector bit positions
`define LEC_EV_TRAIN 0
`define LEC_EV_DLLPROT 1
`define LEC_EV_FCPROT 2
`define LEC_EV_MALF 3
`define LEC_EV_RXOVF 4
`define LEC_EV_RXERR 5
`define LEC_EV_BADPKT 6
`define LEC_EV_BADLNK 7
`define LEC_EV_RPLTO 8
`define LEC_EV_RPLROLL 9
`define LEC_EV_POISON 10
`define LEC_EV_ECRC 11
`define LEC_EV_UR 12
`define LEC_EV_CPLTO 13
`define LEC_EV_CA 14
`define LEC_EV_UC 15
`define LEC_EV_ACS 16
`define LEC_NUM_EV 17
// class masks over the event vector
`define LEC_FATAL_MASK 17'h0001F
`define LEC_CORR_MASK 17'h003E0
`define LEC_NF_MASK 17'h1FC00
// device status bit positions
`define LEC_ST_CORR 0
`define LEC_ST_NF 1
`define LEC_ST_FATAL 2
`define LEC_ST_UR 3
`define LEC_ST_RST 4'h0
// device control enable positions
`define LEC_EN_CORR 0
`define LEC_EN_NF 1
`define LEC_EN_FATAL 2
`define LEC_EN_UR 3
// message codes
`define LEC_MSG_CORR 2'h0
`define LEC_MSG_NF 2'h1
`define LEC_MSG_FATAL 2'h3
// timing
`define LEC_ACK_TO_NS 2000
`define LEC_CPL_TO_NS 50000000
`define LEC_CLK_NS 10
`define LEC_ACK_TO_CYC (`LEC_ACK_TO_NS / `LEC_CLK_NS)
`define LEC_CPL_TO_CYC (`LEC_CPL_TO_NS / `LEC_CLK_NS)
`define LEC_ROLL_MAX 2'h3
`endif

// file: lec_bar_match.v
// address check against the base address ranges
`timescale 1ns/1ns
module lec_bar_match #(
    parameter NUM_BAR = 2,
    parameter AW = 32
) (
    // request address
    input wire [AW-1:0] req_addr,
    // ranges, packed base and limit per bar
    input wire [NUM_BAR*AW-1:0] bar_base,
    input wire [NUM_BAR*AW-1:0] bar_limit,
    input wire [NUM_BAR-1:0] bar_en,
    // result
    output wire hit
);
    wire [NUM_BAR-1:0] hit_vec;
    genvar i;
    // one comparator pair per bar
    generate
        for (i = 0; i < NUM_BAR; i = i + 1)
        begin : g_bar
            assign hit_vec[i] = bar_en[i] &&
                (req_addr >= bar_base[i*AW +: AW]) &&
                (req_addr <= bar_limit[i*AW +: AW]);
        end
    endgenerate
    assign hit = |hit_vec; // outside every range means no hit
endmodule // lec_bar_match

// file: lec_link_error_classifier.v
// link error classifier: detect, classify, record and report link errors
`timescale 1ns/1ns
`include "lec_defines.vh"
module lec_link_error_classifier #(
    parameter NUM_BAR = 2,
    parameter AW = 32,
    parameter ACK_TO_CYC = `LEC_ACK_TO_CYC,
    parameter CPL_TO_CYC = `LEC_CPL_TO_CYC
) (
    // clock and reset
    input wire mclk,
    input wire rstn,
    // external event pins, asynchronous
    input wire train_err,
    input wire dll_prot_err,
    input wire fc_prot_err,
    input wire rx_overflow,
    input wire rx_phy_err,
    // receive path checks, same clock
    input wire rx_pkt_valid,
    input wire rx_pkt_crc_bad,
    input wire rx_pkt_malformed,
    input wire rx_pkt_poisoned,
    input wire rx_pkt_ecrc_bad,
    input wire rx_pkt_is_req,
    input wire rx_pkt_is_cpl,
    input wire rx_pkt_ca,
    input wire rx_pkt_acs_viol,
    input wire [AW-1:0] rx_pkt_addr,
    input wire rx_lnk_valid,
    input wire rx_lnk_crc_bad,
    input wire rx_ack,
    // base address ranges
    input wire [NUM_BAR*AW-1:0] bar_base,
    input wire [NUM_BAR*AW-1:0] bar_limit,
    input wire [NUM_BAR-1:0] bar_en,
    // transmit side
    input wire tx_pkt_sent,
    input wire tx_req_sent,
    // device control enables and status clear
    input wire [3:0] dev_ctrl_en,
    input wire [3:0] dev_status_clr,
    // outputs
    output reg [3:0] dev_status_ff,
    output reg msg_valid_ff,
    output reg [1:0] msg_code_ff,
    output reg replay_req_ff,
    output reg [`LEC_NUM_EV-1:0] ev_seen_ff
);
    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    reg [4:0] pin_s1_ff;
    reg [4:0] pin_s2_ff;
    reg [4:0] pin_d_ff;
    wire [4:0] pin_raw = {rx_phy_err, rx_overflow, fc_prot_err, dll_prot_err, train_err};
    // two stages; only the second stage feeds edge detection
    always @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            pin_s1_ff <= 5'h00;
            pin_s2_ff <= 5'h00;
            pin_d_ff <= 5'h00;
        end
        else
        begin
            pin_s1_ff <= pin_raw;
            pin_s2_ff <= pin_s1_ff;
            pin_d_ff <= pin_s2_ff;
        end
    end
    wire [4:0] pin_rise = pin_s2_ff & ~pin_d_ff; // level pins count once per assertion

    // ****************************************************************
    // receive checks
    // ****************************************************************
    wire bar_hit;
    lec_bar_match #(
        .NUM_BAR(NUM_BAR),
        .AW(AW)
    ) u_bar (
        .req_addr(rx_pkt_addr),
        .bar_base(bar_base),
        .bar_limit(bar_limit),
        .bar_en(bar_en),
        .hit(bar_hit)
    );
    // a crc-bad packet is only a bad packet; its contents are not trusted
    wire pkt_ok = rx_pkt_valid && !rx_pkt_crc_bad;
    wire ev_badpkt = rx_pkt_valid && rx_pkt_crc_bad;
    wire ev_badlnk = rx_lnk_valid && rx_lnk_crc_bad;
    wire ev_malf = pkt_ok && rx_pkt_malformed;
    wire pkt_good = pkt_ok && !rx_pkt_malformed;
    wire ev_poison = pkt_good && rx_pkt_poisoned;
    wire ev_ecrc = pkt_good && !rx_pkt_poisoned && rx_pkt_ecrc_bad;
    wire pkt_clean = pkt_good && !rx_pkt_poisoned && !rx_pkt_ecrc_bad;
    wire ev_ur = pkt_clean && rx_pkt_is_req && !bar_hit;
    wire ev_acs = pkt_clean && rx_pkt_is_req && bar_hit && rx_pkt_acs_viol;
    wire ev_ca = pkt_clean && rx_pkt_is_cpl && rx_pkt_ca;

    // ****************************************************************
    // replay timer and rollover
    // ****************************************************************
    reg [31:0] ack_cnt_ff;
    reg ack_wait_ff;
    reg [1:0] roll_cnt_ff;
    wire ack_expire = ack_wait_ff && (ack_cnt_ff == 32'h00000000);
    wire ev_rplto = ack_expire;
    wire ev_rplroll = ack_expire && (roll_cnt_ff == `LEC_ROLL_MAX);
    // timer restarts on each send or replay; an ack stops it and wins over a send in the same cycle
    always @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            ack_cnt_ff <= 32'h00000000;
            ack_wait_ff <= 1'b0;
            roll_cnt_ff <= 2'h0;
            replay_req_ff <= 1'b0;
        end
        else
        begin
            replay_req_ff <= ack_expire;
            if (rx_ack)
            begin
                ack_wait_ff <= 1'b0;
                roll_cnt_ff <= 2'h0;
            end
            else if (tx_pkt_sent || ack_expire)
            begin
                ack_wait_ff <= 1'b1;
                ack_cnt_ff <= ACK_TO_CYC - 1;
                if (ack_expire)
                    roll_cnt_ff <= roll_cnt_ff + 2'h1;
            end
            else if (ack_wait_ff)
                ack_cnt_ff <= ack_cnt_ff - 32'h00000001;
        end
    end

    // ****************************************************************
    // completion timer
    // ****************************************************************
    reg [31:0] cpl_cnt_ff;
    reg cpl_wait_ff;
    wire cpl_arrive = pkt_clean && rx_pkt_is_cpl;
    wire cpl_expire = cpl_wait_ff && (cpl_cnt_ff == 32'h00000000);
    wire ev_cplto = cpl_expire;
    // completion with nothing outstanding; an abort status already names the cause
    wire ev_uc = cpl_arrive && !rx_pkt_ca && !cpl_wait_ff;
    // single outstanding request tracked; a simplification for small requesters
    always @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            cpl_cnt_ff <= 32'h00000000;
            cpl_wait_ff <= 1'b0;
        end
        else if (tx_req_sent)
        begin
            cpl_wait_ff <= 1'b1;
            cpl_cnt_ff <= CPL_TO_CYC - 1;
        end
        else if (cpl_arrive || cpl_expire)
            cpl_wait_ff <= 1'b0;
        else if (cpl_wait_ff)
            cpl_cnt_ff <= cpl_cnt_ff - 32'h00000001;
    end

    // ****************************************************************
    // classification
    // ****************************************************************
    wire [`LEC_NUM_EV-1:0] ev;
    assign ev[`LEC_EV_TRAIN] = pin_rise[0];
    assign ev[`LEC_EV_DLLPROT] = pin_rise[1];
    assign ev[`LEC_EV_FCPROT] = pin_rise[2];
    assign ev[`LEC_EV_MALF] = ev_malf;
    assign ev[`LEC_EV_RXOVF] = pin_rise[3];
    assign ev[`LEC_EV_RXERR] = pin_rise[4];
    assign ev[`LEC_EV_BADPKT] = ev_badpkt;
    assign ev[`LEC_EV_BADLNK] = ev_badlnk;
    assign ev[`LEC_EV_RPLTO] = ev_rplto;
    assign ev[`LEC_EV_RPLROLL] = ev_rplroll;
    assign ev[`LEC_EV_POISON] = ev_poison;
    assign ev[`LEC_EV_ECRC] = ev_ecrc;
    assign ev[`LEC_EV_UR] = ev_ur;
    assign ev[`LEC_EV_CPLTO] = ev_cplto;
    assign ev[`LEC_EV_CA] = ev_ca;
    assign ev[`LEC_EV_UC] = ev_uc;
    assign ev[`LEC_EV_ACS] = ev_acs;
    // masks are disjoint so each event lands in one class
    wire cls_fatal = |(ev & `LEC_FATAL_MASK);
    wire cls_corr = |(ev & `LEC_CORR_MASK);
    wire cls_nf = |(ev & `LEC_NF_MASK);
    // transmitted traffic has no event input here, so own status never sees it

    // ****************************************************************
    // status and messages
    // ****************************************************************
    reg [3:0] nxt_status;
    reg nxt_msg_valid;
    reg [1:0] nxt_msg_code;
    wire ur_allow = !ev_ur || dev_ctrl_en[`LEC_EN_UR];
    // set wins over clear; most severe message sent when several coincide
    always @*
    begin
        nxt_status = dev_status_ff & ~dev_status_clr;
        if (cls_corr)
            nxt_status[`LEC_ST_CORR] = 1'b1;
        if (cls_nf)
            nxt_status[`LEC_ST_NF] = 1'b1;
        if (cls_fatal)
            nxt_status[`LEC_ST_FATAL] = 1'b1;
        if (ev_ur)
            nxt_status[`LEC_ST_UR] = 1'b1;
        nxt_msg_valid = 1'b0;
        nxt_msg_code = `LEC_MSG_CORR;
        if (cls_fatal && dev_ctrl_en[`LEC_EN_FATAL])
        begin
            nxt_msg_valid = 1'b1;
            nxt_msg_code = `LEC_MSG_FATAL;
        end
        else if (cls_nf && dev_ctrl_en[`LEC_EN_NF] && ur_allow)
        begin
            nxt_msg_valid = 1'b1;
            nxt_msg_code = `LEC_MSG_NF;
        end
        else if (cls_corr && dev_ctrl_en[`LEC_EN_CORR])
        begin
            nxt_msg_valid = 1'b1;
            nxt_msg_code = `LEC_MSG_CORR;
        end
    end
    // registered outputs
    always @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            dev_status_ff <= `LEC_ST_RST;
            msg_valid_ff <= 1'b0;
            msg_code_ff <= `LEC_MSG_CORR;
            ev_seen_ff <= {`LEC_NUM_EV{1'b0}};
        end
        else
        begin
            dev_status_ff <= nxt_status;
            msg_valid_ff <= nxt_msg_valid;
            msg_code_ff <= nxt_msg_code;
            ev_seen_ff <= ev; // debug view of the cause, one cycle per event
        end
    end
endmodule // lec_link_error_classifier

// file: lec_link_error_classifier_props.sv
// assertions watching the link error classifier ports
`timescale 1ns/1ns
`include "lec_defines.vh"
module lec_link_error_classifier_props (
    // clock and reset
    input wire mclk,
    input wire rstn,
    // watched inputs
    input wire train_err,
    input wire rx_pkt_valid,
    input wire rx_pkt_crc_bad,
    input wire [3:0] dev_ctrl_en,
    // watched outputs
    input wire [3:0] dev_status_ff,
    input wire msg_valid_ff,
    input wire [1:0] msg_code_ff,
    input wire replay_req_ff,
    input wire [`LEC_NUM_EV-1:0] ev_seen_ff
);
    // one clock domain, so clock and reset are shared by every check
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);
    fatal_status_a: assert property (
        |(ev_seen_ff & `LEC_FATAL_MASK) |-> dev_status_ff[`LEC_ST_FATAL])
        else $error("fatal event left status clear");
    nonfatal_status_a: assert property (
        |(ev_seen_ff & `LEC_NF_MASK) |-> dev_status_ff[`LEC_ST_NF])
        else $error("non-fatal event left status clear");
    unsupported_status_a: assert property (
        ev_seen_ff[`LEC_EV_UR] |-> dev_status_ff[`LEC_ST_UR] && dev_status_ff[`LEC_ST_NF])
        else $error("unsupported request not recorded");
    fatal_msg_gate_a: assert property (
        msg_valid_ff && msg_code_ff == `LEC_MSG_FATAL |-> $past(dev_ctrl_en[`LEC_EN_FATAL]))
        else $error("fatal message while disabled");
    msg_has_cause_a: assert property (
        msg_valid_ff |-> |ev_seen_ff)
        else $error("message without an event");
    replay_cause_a: assert property (
        replay_req_ff |-> ev_seen_ff[`LEC_EV_RPLTO])
        else $error("resend without replay timeout");
    bad_pkt_class_a: assert property (
        rx_pkt_valid && rx_pkt_crc_bad |=> ev_seen_ff[`LEC_EV_BADPKT] && !ev_seen_ff[`LEC_EV_MALF])
        else $error("bad packet misclassified");
    pin_event_a: assert property (
        $rose(train_err) |-> ##[2:4] ev_seen_ff[`LEC_EV_TRAIN])
        else $error("training error pin not seen");
    // main scenarios reached
    cover property (msg_valid_ff && msg_code_ff == `LEC_MSG_FATAL);
    cover property (replay_req_ff);
    cover property (ev_seen_ff[`LEC_EV_UR]);
endmodule // lec_link_error_classifier_props
bind lec_link_error_classifier lec_link_error_classifier_props props_inst (.mclk, .rstn,
    .train_err, .rx_pkt_valid, .rx_pkt_crc_bad, .dev_ctrl_en, .dev_status_ff, .msg_valid_ff,
    .msg_code_ff, .replay_req_ff, .ev_seen_ff);

// file: lec_link_partner.sv
// link partner model: acks the latest transmitted packet after a set nonzero delay
`timescale 1ns/1ns
module lec_link_partner (
    // clock and reset
    input wire mclk,
    input wire rstn,
    // packet sent and ack delay, zero never acks
    input wire tx_pkt_sent,
    input wire [7:0] ack_dly,
    // ack back to the device
    output reg rx_ack_ff
);
    reg [7:0] wait_ff;
    // a new packet restarts the wait; a partner with zero delay simply never answers
    always @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            wait_ff <= 8'h00;
            rx_ack_ff <= 1'b0;
        end
        else
        begin
            rx_ack_ff <= wait_ff == 8'h01;
            wait_ff <= tx_pkt_sent ? ack_dly : wait_ff - {7'h00, wait_ff != 8'h00};
        end
    end
endmodule // lec_link_partner

// file: lec_link_error_classifier_test.sv
// self-checking bench for the link error classifier
`timescale 1ns/1ns
`include "lec_defines.vh"
module lec_link_error_classifier_test;
    localparam ACK = 8;
    localparam CPL = 20;
    logic mclk, rstn, lnk_v, lnk_bad, tx_sent, tx_req;
    logic [4:0] pins;
    logic [8:0] pk; // valid crc malformed poisoned ecrc req cpl abort acs
    logic [7:0] addr, ack_dly;
    logic [1:0] ben;
    logic [3:0] en, clr;
    logic [`LEC_NUM_EV-1:0] acc;
    wire ack, mv, rpl;
    wire [3:0] st;
    wire [1:0] mc;
    wire [`LEC_NUM_EV-1:0] ev;
    int error_cnt, samples_checked, cyc, n, k, e;
    lec_link_error_classifier #(.NUM_BAR(2), .AW(8), .ACK_TO_CYC(ACK), .CPL_TO_CYC(CPL))
        lec_link_error_classifier_inst (.mclk(mclk), .rstn(rstn), .train_err(pins[0]),
        .dll_prot_err(pins[1]), .fc_prot_err(pins[2]), .rx_overflow(pins[3]),
        .rx_phy_err(pins[4]), .rx_pkt_valid(pk[0]), .rx_pkt_crc_bad(pk[1]),
        .rx_pkt_malformed(pk[2]), .rx_pkt_poisoned(pk[3]), .rx_pkt_ecrc_bad(pk[4]),
        .rx_pkt_is_req(pk[5]), .rx_pkt_is_cpl(pk[6]), .rx_pkt_ca(pk[7]),
        .rx_pkt_acs_viol(pk[8]), .rx_pkt_addr(addr), .rx_lnk_valid(lnk_v),
        .rx_lnk_crc_bad(lnk_bad), .rx_ack(ack), .bar_base(16'h8010), .bar_limit(16'h9F2F),
        .bar_en(ben), .tx_pkt_sent(tx_sent), .tx_req_sent(tx_req), .dev_ctrl_en(en),
        .dev_status_clr(clr), .dev_status_ff(st), .msg_valid_ff(mv), .msg_code_ff(mc),
        .replay_req_ff(rpl), .ev_seen_ff(ev));
    lec_link_partner lec_link_partner_inst (.mclk(mclk), .rstn(rstn), .tx_pkt_sent(tx_sent),
        .ack_dly(ack_dly), .rx_ack_ff(ack));
    // 100 MHz clock
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // gather events between checks; cut a hang short well past the expected run
    always @(posedge mclk)
    begin
        acc <= acc | ev;
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            error_cnt++;
            report_and_stop();
        end
    end
    task tick();
        @(posedge mclk);
        #1;
    endtask
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, got);
        end
    endtask
    task clear_st();
        clr = 4'hF;
        tick();
        clr = 4'h0;
    endtask
    task report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // event due for a packet in precedence order, -1 when clean; nothing outstanding
    function automatic int pkt_ev(logic [8:0] p, logic [7:0] a, logic [1:0] b);
        if (p[1]) return `LEC_EV_BADPKT;
        if (p[2]) return `LEC_EV_MALF;
        if (p[3]) return `LEC_EV_POISON;
        if (p[4]) return `LEC_EV_ECRC;
        if (p[5] && !(b[0] && a >= 8'h10 && a <= 8'h2F || b[1] && a >= 8'h80 && a <= 8'h9F))
            return `LEC_EV_UR;
        if (p[5]) return p[8] ? `LEC_EV_ACS : -1;
        return p[7] ? `LEC_EV_CA : `LEC_EV_UC;
    endfunction
    initial
    begin
        k = $urandom(19);
        {rstn, pins, pk, addr, ack_dly, ben, en, clr, lnk_v, lnk_bad, tx_sent, tx_req} = 0;
        {acc, cyc, error_cnt, samples_checked} = 0;
        repeat (12) tick();
        rstn = 1'b1;
        // random packets with rare faults and random enables
        for (int i = 0; i < 80; i++)
        begin
            pk = 9'h001 | (9'($urandom) & 9'h1E0);
            for (k = 1; k < 5; k++) pk[k] = ($urandom_range(5) == 0);
            pk[6] = !pk[5];
            {addr, ben, en} = 14'($urandom);
            e = pkt_ev(pk, addr, ben);
            tick();
            pk = 9'h000;
            chk("events", e < 0 ? 0 : 1 << e, ev);
            n = e < 0 ? 0 : (`LEC_FATAL_MASK >> e) & 1 ? 2 : (`LEC_CORR_MASK >> e) & 1 ? 0 : 1;
            chk("status", e < 0 ? 0 : 1 << n | (e == `LEC_EV_UR ? 8 : 0), st);
            chk("message", e >= 0 && en[n] && (e != `LEC_EV_UR || en[3]), mv);
            if (mv === 1'b1) chk("code", n == 2 ? 3 : n, mc);
            clear_st();
        end
        $display("packet test done");
        // each pin, then a bad and a good link packet
        for (k = 0; k < 7; k++)
        begin
            acc = 0;
            if (k < 5) pins[k] = 1'b1;
            else {lnk_v, lnk_bad} = {1'b1, k == 5};
            tick();
            {lnk_v, lnk_bad} = 2'b00;
            repeat (5) tick();
            pins = 5'h00;
            n = k == 6 ? 0 : k == 5 ? 1 << 7 : k > 2 ? 1 << k + 1 : 1 << k;
            chk("pin or link event", n, acc);
            chk("pin or link status", k == 6 ? 0 : k > 3 ? 1 : 4, st);
            clear_st();
        end
        $display("pin test done");
        // silent partner: four replays, rollover only on the fourth
        acc = 0;
        tx_sent = 1'b1;
        tick();
        tx_sent = 1'b0;
        for (k = 0; k < 4; k++)
        begin
            n = 0;
            do
            begin
                tick();
                n++;
            end
            while (rpl !== 1'b1 && n < 99);
            if (k == 0) chk("replay delay", ACK, n);
            tick();
            chk("rollover", k == 3, acc[`LEC_EV_RPLROLL]);
        end
        chk("replay status", 1, st);
        // prompt partner: an acked packet is never replayed
        ack_dly = 8'h03;
        tx_sent = 1'b1;
        tick();
        tx_sent = 1'b0;
        acc = 0;
        repeat (3 * ACK) tick();
        chk("acked replay", 0, acc);
        // request left unanswered, then answered in time
        for (k = 0; k < 2; k++)
        begin
            acc = 0;
            tx_req = 1'b1;
            tick();
            tx_req = 1'b0;
            repeat (5) tick();
            pk = k ? 9'h041 : 9'h000;
            tick();
            pk = 9'h000;
            repeat (CPL) tick();
            chk("completion wait", k ? 0 : 1 << `LEC_EV_CPLTO, acc);
        end
        $display("timer test done");
        report_and_stop();
    end
endmodule // lec_link_error_classifier_test
